// file: xlc_pkg.sv
// package for the crosslink link-state control block
// assumes a classic wishbone slave with 32-bit data and byte addresses
package xlc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_LINK_CONTROL_REG    = 8'h00;
  localparam logic [7:0] ADDR_PHY_LINK_CONFIG_ZERO = 8'h04;
  localparam logic [7:0] ADDR_PHY_LINK_STATE_ZERO  = 8'h08;
  localparam logic [7:0] ADDR_PORT_CONFIG          = 8'h0c;
  // field positions
  localparam int LINK_OFF_REQUEST_BIT     = 4;
  localparam int LEGACY_COMPAT_ENABLE_BIT = 0;
  localparam int FULL_RETRAIN_TRIGGER_BIT = 0;
  localparam int COMPAT_ACTIVE_BIT        = 1;
  localparam int LTSSM_LSB                = 8;
  localparam int PORT_UPSTREAM_BIT        = 0;
  localparam int PORT_OFF_MODE_BIT        = 1;
  // training-set symbol 4 bits that compatibility mode clears
  localparam logic [7:0] TS_SYM4_NEW_BITS = 8'hc4;
  // reset values and the unmapped read value
  localparam logic [31:0] RST_LINK_CONTROL_REG     = 32'h0000_0000;
  localparam logic [31:0] RST_PHY_LINK_CONFIG_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_PORT_CONFIG          = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ            = 32'h0000_0000;
  // cycles spent in recovery before moving on
  localparam int RECOVERY_NS     = 100;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int RECOVERY_CYCLES = (RECOVERY_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  // link states
  typedef enum logic [5:0] {
    XLC_DETECT   = 6'h01,
    XLC_TRAIN    = 6'h02,
    XLC_L0       = 6'h04,
    XLC_RECOVERY = 6'h08,
    XLC_HOTRST   = 6'h10,
    XLC_DISABLED = 6'h20
  } xlc_state_t;
endpackage

// file: xlc_sync.sv
// three-stage synchroniser for one pin input
// assumes the input is asynchronous to CLK
`timescale 1ns/1ps
module xlc_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic s1;
  logic s2;
  logic s3;
  logic next_dout;

  always_comb begin
    next_dout = dout;
    if (s2 == s3) begin
      next_dout = s3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end
endmodule

// file: xlc_link_ctrl.sv
// link-state control for one crosslinked switch port
// assumes received training-set flags arrive asynchronously on pins
`timescale 1ns/1ps
module xlc_link_ctrl (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O,
  input  wire logic        RX_HOT_RESET,
  input  wire logic        RX_DISABLE,
  input  wire logic        RX_TRAINED,
  input  wire logic        RX_ELEC_IDLE,
  input  wire logic [7:0]  TX_SYM4_IN,
  output logic [7:0]       TX_SYM4,
  output logic [5:0]       LINK_STATE,
  output logic             COMPAT_ACTIVE
);
  ////////////////////////////////////////////////////////////////////////
  logic hot_s;
  logic dis_s;
  logic trn_s;
  logic idle_s;

  xlc_sync u_hot (.clk(CLK), .rst(RST), .din(RX_HOT_RESET), .dout(hot_s));
  xlc_sync u_dis (.clk(CLK), .rst(RST), .din(RX_DISABLE), .dout(dis_s));
  xlc_sync u_trn (.clk(CLK), .rst(RST), .din(RX_TRAINED), .dout(trn_s));
  xlc_sync u_idl (.clk(CLK), .rst(RST), .din(RX_ELEC_IDLE), .dout(idle_s));

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] link_control_reg;
  logic [31:0] phy_link_config_zero;
  logic [31:0] port_config;
  logic        retrain_pend;
  logic [31:0] next_link_control_reg;
  logic [31:0] next_phy_link_config_zero;
  logic [31:0] next_port_config;
  logic        next_retrain_pend;
  logic [31:0] next_dat_o;
  logic        next_ack_o;
  logic        wr_req;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = val[8*i +: 8];
      end
    end
    return r;
  endfunction

  xlc_pkg::xlc_state_t state;
  xlc_pkg::xlc_state_t next_state;
  logic                compat;
  logic                next_compat;
  logic [7:0]          rcnt;
  logic [7:0]          next_rcnt;
  logic [7:0]          next_tx_sym4;
  logic                upstream;
  logic                off_mode;
  logic                link_off;

  assign upstream = port_config[xlc_pkg::PORT_UPSTREAM_BIT];
  assign off_mode = port_config[xlc_pkg::PORT_OFF_MODE_BIT];
  // software link-off ignored in upstream mode
  assign link_off = link_control_reg[xlc_pkg::LINK_OFF_REQUEST_BIT]
                    && !upstream;

  always_comb begin
    wr_req = CYC_I && STB_I && WE_I && !ACK_O;
    next_ack_o = CYC_I && STB_I && !ACK_O;
    next_link_control_reg = link_control_reg;
    next_phy_link_config_zero = phy_link_config_zero;
    next_port_config = port_config;
    next_retrain_pend = retrain_pend;
    next_dat_o = DAT_O;
    // cleared on reaching detect; a new trigger in the same cycle wins
    if (state == xlc_pkg::XLC_DETECT) begin
      next_retrain_pend = 1'b0;
    end
    if (wr_req) begin
      case (ADR_I)
        xlc_pkg::ADDR_LINK_CONTROL_REG:
          next_link_control_reg = merge(link_control_reg, DAT_I, SEL_I);
        xlc_pkg::ADDR_PHY_LINK_CONFIG_ZERO:
          next_phy_link_config_zero =
            merge(phy_link_config_zero, DAT_I, SEL_I);
        xlc_pkg::ADDR_PHY_LINK_STATE_ZERO: begin
          if (SEL_I[0] && DAT_I[xlc_pkg::FULL_RETRAIN_TRIGGER_BIT]) begin
            next_retrain_pend = 1'b1;
          end
        end
        xlc_pkg::ADDR_PORT_CONFIG:
          next_port_config = merge(port_config, DAT_I, SEL_I);
        default: ;
      endcase
    end
    if (next_ack_o && !WE_I) begin
      case (ADR_I)
        xlc_pkg::ADDR_LINK_CONTROL_REG: next_dat_o = link_control_reg;
        xlc_pkg::ADDR_PHY_LINK_CONFIG_ZERO: next_dat_o = phy_link_config_zero;
        xlc_pkg::ADDR_PHY_LINK_STATE_ZERO: begin
          next_dat_o = 32'h0000_0000;
          next_dat_o[xlc_pkg::FULL_RETRAIN_TRIGGER_BIT] = retrain_pend;
          next_dat_o[xlc_pkg::COMPAT_ACTIVE_BIT] = compat;
          next_dat_o[xlc_pkg::LTSSM_LSB +: 6] = state;
        end
        xlc_pkg::ADDR_PORT_CONFIG: next_dat_o = port_config;
        default: next_dat_o = xlc_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      link_control_reg     <= xlc_pkg::RST_LINK_CONTROL_REG;
      phy_link_config_zero <= xlc_pkg::RST_PHY_LINK_CONFIG_ZERO;
      port_config          <= xlc_pkg::RST_PORT_CONFIG;
      retrain_pend         <= 1'b0;
      DAT_O                <= 32'h0000_0000;
      ACK_O                <= 1'b0;
    end else begin
      link_control_reg     <= next_link_control_reg;
      phy_link_config_zero <= next_phy_link_config_zero;
      port_config          <= next_port_config;
      retrain_pend         <= next_retrain_pend;
      DAT_O                <= next_dat_o;
      ACK_O                <= next_ack_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link state machine; hot reset only from received sets
  always_comb begin
    next_state = state;
    next_rcnt = 8'h00;
    next_compat = compat;
    case (state)
      xlc_pkg::XLC_DETECT: begin
        // mode latched only on a requested full retrain
        if (retrain_pend) begin
          next_compat = phy_link_config_zero[
            xlc_pkg::LEGACY_COMPAT_ENABLE_BIT];
        end
        if (!off_mode && !retrain_pend) begin
          next_state = xlc_pkg::XLC_TRAIN;
        end
      end
      xlc_pkg::XLC_TRAIN: begin
        if (trn_s) begin
          next_state = xlc_pkg::XLC_L0;
        end
      end
      xlc_pkg::XLC_L0: begin
        if (hot_s) begin
          next_state = xlc_pkg::XLC_HOTRST;
        end else if (dis_s) begin
          next_state = xlc_pkg::XLC_DISABLED;
        end else if (link_off) begin
          next_state = xlc_pkg::XLC_RECOVERY;
        end else if (retrain_pend) begin
          next_state = xlc_pkg::XLC_DETECT;
        end
      end
      xlc_pkg::XLC_RECOVERY: begin
        next_rcnt = rcnt + 8'h01;
        if (dis_s) begin
          next_state = xlc_pkg::XLC_DISABLED;
        end else if (rcnt >= 8'(xlc_pkg::RECOVERY_CYCLES - 1)) begin
          next_state = xlc_pkg::XLC_DISABLED;
        end
      end
      xlc_pkg::XLC_HOTRST: begin
        if (!hot_s) begin
          next_state = xlc_pkg::XLC_DETECT;
        end
      end
      xlc_pkg::XLC_DISABLED: begin
        if (!dis_s && !link_off && !idle_s) begin
          next_state = xlc_pkg::XLC_DETECT;
        end
      end
      default: next_state = xlc_pkg::XLC_DETECT;
    endcase
    // off operating mode forces detect, never disabled
    if (off_mode) begin
      next_state = xlc_pkg::XLC_DETECT;
    end
    // clear new symbol 4 bits while compatible
    next_tx_sym4 = next_compat ? (TX_SYM4_IN & ~xlc_pkg::TS_SYM4_NEW_BITS)
                               : TX_SYM4_IN;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state         <= xlc_pkg::XLC_DETECT;
      rcnt          <= 8'h00;
      compat        <= 1'b0;
      TX_SYM4       <= 8'h00;
      LINK_STATE    <= 6'h01;
      COMPAT_ACTIVE <= 1'b0;
    end else begin
      state         <= next_state;
      rcnt          <= next_rcnt;
      compat        <= next_compat;
      TX_SYM4       <= next_tx_sym4;
      LINK_STATE    <= next_state;
      COMPAT_ACTIVE <= next_compat;
    end
  end
endmodule

// file: xlc_link_ctrl_asserts.sv
// checker for the crosslink link-state control block
// assumes it is bound to xlc_link_ctrl and sees only its ports
`timescale 1ns/1ps
module xlc_link_ctrl_asserts (
  input wire logic       CLK, RST, CYC_I, STB_I, ACK_O, COMPAT_ACTIVE,
  input wire logic       RX_HOT_RESET, RX_DISABLE,
  input wire logic [7:0] TX_SYM4_IN, TX_SYM4,
  input wire logic [5:0] LINK_STATE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  sequence s_rec_in;
    $rose(LINK_STATE == 6'h08);
  endsequence
  sequence s_rec_hold;
    ##9 (LINK_STATE == 6'h08) ##1 (LINK_STATE != 6'h08);
  endsequence
  sequence s_dis_req;
    (LINK_STATE == 6'h04 && RX_DISABLE) ##1 RX_DISABLE [*8];
  endsequence
  ////////////////////////////////////////
  AST_ACK_TAKEN: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  AST_TX_MASKED: assert property (
    COMPAT_ACTIVE && $past(COMPAT_ACTIVE) |-> (TX_SYM4 & 8'hc4) == 8'h00)
    else $error("newer symbol 4 bits sent in compat mode");
  AST_TX_PASS: assert property (
    !$past(RST) && !COMPAT_ACTIVE && !$past(COMPAT_ACTIVE)
    |-> TX_SYM4 == $past(TX_SYM4_IN))
    else $error("symbol 4 altered outside compat mode");
  AST_COMPAT_AT_RETRAIN: assert property (
    $changed(COMPAT_ACTIVE) |-> $past(LINK_STATE) == 6'h01)
    else $error("compat mode changed outside a retrain");
  AST_RECOVERY_TIME: assert property (s_rec_in |-> s_rec_hold)
    else $error("recovery not ten cycles");
  AST_HOT_FROM_PIN: assert property (
    $rose(LINK_STATE == 6'h10) |-> $past(RX_HOT_RESET, 5))
    else $error("hot reset without received hot reset sets");
  AST_DIS_FROM_PIN: assert property (
    s_dis_req |-> ##[0:20] (LINK_STATE == 6'h20))
    else $error("received disabled sets ignored");
endmodule
bind xlc_link_ctrl xlc_link_ctrl_asserts u_chk (.*);

// file: xlc_partner.sv
// link partner model sending training-set flags
// assumes the bench requests hot reset and disabled sets
`timescale 1ns/1ps
module xlc_partner (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [5:0] link_state,
  input  wire logic       send_hot,
  input  wire logic       send_dis,
  output logic            rx_hot,
  output logic            rx_dis,
  output logic            rx_trained,
  output logic            rx_idle
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_hot     <= 1'b0;
      rx_dis     <= 1'b0;
      rx_trained <= 1'b0;
      rx_idle    <= 1'b0;
    end else begin
      rx_hot     <= send_hot;
      rx_dis     <= send_dis;
      rx_idle    <= send_dis && link_state == 6'h20;
      rx_trained <= link_state == 6'h02 || link_state == 6'h04;
    end
  end
endmodule

// file: xlc_link_ctrl_tb.sv
// testbench for the crosslink link-state control block
// assumes the partner model and the bound checker
`timescale 1ns/1ps
module xlc_link_ctrl_tb;
  logic        clk, rst, cyc, stb, we, ack, compat, hot, dis;
  logic        rx_hot, rx_dis, rx_tr, rx_idle;
  logic [7:0]  adr, tx, sym;
  logic [31:0] wdat, rdat;
  logic [5:0]  st;
  int          miscompares, n_checks;
  logic [7:0]  ra [4] = '{8'h00, 8'h04, 8'h0c, 8'h10};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  xlc_link_ctrl dut (.CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(wdat), .DAT_O(rdat),
    .ACK_O(ack), .RX_HOT_RESET(rx_hot), .RX_DISABLE(rx_dis),
    .RX_TRAINED(rx_tr), .RX_ELEC_IDLE(rx_idle), .TX_SYM4_IN(sym),
    .TX_SYM4(tx), .LINK_STATE(st), .COMPAT_ACTIVE(compat));
  xlc_partner u_far (.clk(clk), .rst(rst), .link_state(st),
    .send_hot(hot), .send_dis(dis), .rx_hot(rx_hot), .rx_dis(rx_dis),
    .rx_trained(rx_tr), .rx_idle(rx_idle));
  ////////////////////////////////////////
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 20) begin
      chk(32'h1, 32'h0);
      finish_test;
    end
  endtask
  task wait_st(input logic [5:0] s);
    for (int i = 0; i < 300 && st !== s; i++) @(posedge clk);
    chk(32'(st), 32'(s));
    if (st !== s) finish_test;
  endtask
  ////////////////////////////////////////
  initial begin
    {rst, cyc, stb, we, hot, dis} = 6'h20;
    adr = 8'h00;
    sym = 8'hff;
    wdat = 32'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[k]) begin
      bus(1'b0, ra[k], 32'h0);
      chk(rdat, 32'h0);
    end
    wait_st(6'h04);
    bus(1'b1, 8'h00, 32'h10);
    wait_st(6'h08);
    wait_st(6'h20);
    bus(1'b1, 8'h00, 32'h0);
    wait_st(6'h04);
    bus(1'b1, 8'h0c, 32'h1);
    bus(1'b1, 8'h00, 32'h10);
    repeat (40) @(posedge clk);
    chk(32'(st), 32'h04);
    bus(1'b1, 8'h00, 32'h0);
    hot <= 1'b1;
    wait_st(6'h10);
    hot <= 1'b0;
    wait_st(6'h04);
    dis <= 1'b1;
    wait_st(6'h20);
    repeat (4) @(posedge clk);
    dis <= 1'b0;
    wait_st(6'h04);
    bus(1'b1, 8'h0c, 32'h0);
    bus(1'b1, 8'h04, 32'h1);
    repeat (20) @(posedge clk);
    chk(32'(compat), 32'h0);
    bus(1'b1, 8'h08, 32'h1);
    wait_st(6'h01);
    wait_st(6'h04);
    chk(32'(tx), 32'h3b);
    chk(32'(compat), 32'h1);
    sym <= 8'hc4;
    repeat (2) @(posedge clk);
    chk(32'(tx), 32'h00);
    bus(1'b0, 8'h08, 32'h0);
    chk(rdat, 32'h0402);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h08, 32'h1);
    wait_st(6'h01);
    wait_st(6'h04);
    chk(32'(tx), 32'hc4);
    chk(32'(compat), 32'h0);
    bus(1'b1, 8'h0c, 32'h2);
    wait_st(6'h01);
    repeat (30) @(posedge clk);
    chk(32'(st), 32'h01);
    finish_test;
  end
endmodule
